// file: verilog/umhp_pkg.sv
// Constants and carrier types for the modem handshake pin block
package umhp_pkg;

    localparam int MCR_W         = 8;
    localparam int MCR_DTR_BIT   = 0;
    localparam int MCR_RTS_BIT   = 1;
    localparam int MCR_LOOP_BIT  = 4;

    localparam int MSR_DCTS_BIT  = 0;
    localparam int MSR_DDSR_BIT  = 1;
    localparam int MSR_TERI_BIT  = 2;
    localparam int MSR_DDCD_BIT  = 3;
    localparam int MSR_CTS_BIT   = 4;
    localparam int MSR_DSR_BIT   = 5;
    localparam int MSR_RI_BIT    = 6;
    localparam int MSR_DCD_BIT   = 7;

    localparam logic [7:0]  MCR_RESET     = 8'h00;
    localparam logic        PIN_INACTIVE  = 1'b1;
    localparam logic        LINE_IDLE     = 1'b1;
    localparam logic        STRAP_RESET   = 1'b0;
    localparam logic [15:0] CFG_BASE_LOW  = 16'h03f0;
    localparam logic [15:0] CFG_BASE_HIGH = 16'h0370;

    // Field order matches the status register from bit 3 down
    typedef struct packed {
        logic carrierDetectN;
        logic ringIndicateN;
        logic setReadyN;
        logic clearToSendN;
    } umhp_modem_in_t;

    // Packed layout is the modem status register, bit 7 first
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] delta;
    } umhp_status_t;

endpackage

// file: verilog/umhp_status.sv
// Modem status tracking for one serial port
`timescale 1ns/10ps
`default_nettype none

module umhp_status
    import umhp_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire umhp_modem_in_t pinsN,
    input  wire logic           statusRead,
    input  wire logic           modemIntEnable,
    output var  umhp_status_t   status,
    output var  logic           modemIrq
);

    umhp_modem_in_t prevN_r;
    logic           primed_r;
    logic [3:0]     delta_r;
    logic [3:0]     delta_nxt;
    logic           pend_r;
    logic           pend_nxt;
    logic [3:0]     level_r;
    logic           irq_r;

    wire logic [3:0] pinVec  = pinsN;
    wire logic [3:0] prevVec = prevN_r;
    // First cycle after reset has no history, so no edge is claimed
    wire logic [3:0] riseVec = primed_r ? (pinVec & ~prevVec) : 4'h0;
    wire logic       anyEdge = primed_r & (|(pinVec ^ prevVec));

    // Set wins over the clear of a read in the same cycle
    assign delta_nxt = (statusRead ? 4'h0 : delta_r) | riseVec;
    assign pend_nxt  = (statusRead ? 1'b0 : pend_r) | anyEdge;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prevN_r  <= '1;
            primed_r <= 1'b0;
            delta_r  <= 4'h0;
            pend_r   <= 1'b0;
            level_r  <= 4'h0;
            irq_r    <= 1'b0;
        end else begin
            prevN_r  <= pinsN;
            primed_r <= 1'b1;
            delta_r  <= delta_nxt;
            pend_r   <= pend_nxt;
            level_r  <= ~pinVec;
            irq_r    <= modemIntEnable & pend_nxt;
        end
    end

    assign status   = '{level: level_r, delta: delta_r};
    assign modemIrq = irq_r;

endmodule

`default_nettype wire

// file: verilog/umhp_top.sv
// Modem handshake pins, status tracking and config strap for two ports
`timescale 1ns/10ps
`default_nettype none

module umhp_top
    import umhp_pkg::*;
#(
    parameter int REG_W = MCR_W
)
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        port1ModemCtrlWe,
    input  wire logic [7:0]  port1ModemCtrlWdata,
    output var  logic [7:0]  port1ModemCtrlReg,
    input  wire logic        port1StatusRead,
    output var  logic [7:0]  port1ModemStatusReg,
    input  wire logic        port1ModemIntEnable,
    output var  logic        port1ModemIrq,
    output var  logic        port1SendRequestN,
    output var  logic        port1TerminalReadyN,
    input  wire logic        port1ClearToSendN,
    input  wire logic        port1SetReadyN,
    input  wire logic        port1CarrierDetectN,
    input  wire logic        port1RingIndicateN,
    input  wire logic        port1SerialIn,
    output var  logic        port1RxData,
    input  wire logic        port1TxData,
    output var  logic        port1SerialOut,
    input  wire logic        port2ModemCtrlWe,
    input  wire logic [7:0]  port2ModemCtrlWdata,
    output var  logic [7:0]  port2ModemCtrlReg,
    input  wire logic        port2StatusRead,
    output var  logic [7:0]  port2ModemStatusReg,
    input  wire logic        port2ModemIntEnable,
    output var  logic        port2ModemIrq,
    output var  logic        port2SendRequestN,
    output var  logic        port2SendRequestOe,
    input  wire logic        port2SendRequestIn,
    output var  logic        port2TerminalReadyN,
    input  wire logic        port2ClearToSendN,
    input  wire logic        port2SetReadyN,
    input  wire logic        port2CarrierDetectN,
    input  wire logic        port2RingIndicateN,
    input  wire logic        port2SerialOrInfraredIn,
    output var  logic        port2RxData,
    output var  logic        port2IrRxData,
    input  wire logic        port2IrMode,
    input  wire logic        port2TxData,
    input  wire logic        port2IrTxData,
    output var  logic        port2SerialOrInfraredOut,
    output var  logic        configBaseStrap,
    output var  logic [15:0] configIndexBase
);

    if (REG_W != MCR_W) begin : g_check
        $error("umhp_top: REG_W must equal the 8-bit control width");
    end

    // Low when the bit is set, held high while loop mode is on
    function automatic logic handshakeN(input logic [7:0] ctrl,
                                        input int        bitIdx);
        handshakeN = ~(ctrl[bitIdx] & ~ctrl[MCR_LOOP_BIT]);
    endfunction

    logic [7:0]  mcr1_r;
    logic [7:0]  mcr2_r;
    logic        rts1N_r;
    logic        dtr1N_r;
    logic        rts2N_r;
    logic        dtr2N_r;
    logic        strapDone_r;
    logic        strap_r;
    logic [15:0] cfgBase_r;
    logic        rx1_r;
    logic        tx1_r;
    logic        rx2_r;
    logic        irRx2_r;
    logic        out2_r;

    umhp_modem_in_t pins1N;
    umhp_modem_in_t pins2N;
    umhp_status_t   status1;
    umhp_status_t   status2;

    wire logic [7:0] mcr1_nxt = port1ModemCtrlWe ? port1ModemCtrlWdata
                                                 : mcr1_r;
    wire logic [7:0] mcr2_nxt = port2ModemCtrlWe ? port2ModemCtrlWdata
                                                 : mcr2_r;
    // Infrared shares the port 2 transmit pin; mode picks the source
    wire logic       out2_nxt = port2IrMode ? port2IrTxData
                                            : port2TxData;
    wire logic [15:0] cfgBase_nxt = port2SendRequestIn ? CFG_BASE_HIGH
                                                       : CFG_BASE_LOW;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mcr1_r <= MCR_RESET;
            mcr2_r <= MCR_RESET;
        end else begin
            mcr1_r <= mcr1_nxt;
            mcr2_r <= mcr2_nxt;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rts1N_r <= PIN_INACTIVE;
            rts2N_r <= PIN_INACTIVE;
            dtr1N_r <= PIN_INACTIVE;
            dtr2N_r <= PIN_INACTIVE;
        end else begin
            rts1N_r <= handshakeN(mcr1_r, MCR_RTS_BIT);
            rts2N_r <= handshakeN(mcr2_r, MCR_RTS_BIT);
            dtr1N_r <= handshakeN(mcr1_r, MCR_DTR_BIT);
            dtr2N_r <= handshakeN(mcr2_r, MCR_DTR_BIT);
        end
    end

    // Strap taken on the first edge after release; driver stays off
    // until then so the board resistor sets the pin level
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strapDone_r <= 1'b0;
            strap_r     <= STRAP_RESET;
            cfgBase_r   <= CFG_BASE_LOW;
        end else if (!strapDone_r) begin
            strapDone_r <= 1'b1;
            strap_r     <= port2SendRequestIn;
            cfgBase_r   <= cfgBase_nxt;
        end
    end

    // Transmit data passes through one register stage; handshake inputs
    // play no part here
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx1_r   <= LINE_IDLE;
            tx1_r   <= LINE_IDLE;
            rx2_r   <= LINE_IDLE;
            irRx2_r <= LINE_IDLE;
            out2_r  <= LINE_IDLE;
        end else begin
            rx1_r   <= port1SerialIn;
            tx1_r   <= port1TxData;
            rx2_r   <= port2SerialOrInfraredIn;
            irRx2_r <= port2SerialOrInfraredIn;
            out2_r  <= out2_nxt;
        end
    end

    assign pins1N = '{carrierDetectN: port1CarrierDetectN,
                      ringIndicateN:  port1RingIndicateN,
                      setReadyN:      port1SetReadyN,
                      clearToSendN:   port1ClearToSendN};
    assign pins2N = '{carrierDetectN: port2CarrierDetectN,
                      ringIndicateN:  port2RingIndicateN,
                      setReadyN:      port2SetReadyN,
                      clearToSendN:   port2ClearToSendN};

    umhp_status u_status1 (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .pinsN          (pins1N),
        .statusRead     (port1StatusRead),
        .modemIntEnable (port1ModemIntEnable),
        .status         (status1),
        .modemIrq       (port1ModemIrq)
    );

    umhp_status u_status2 (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .pinsN          (pins2N),
        .statusRead     (port2StatusRead),
        .modemIntEnable (port2ModemIntEnable),
        .status         (status2),
        .modemIrq       (port2ModemIrq)
    );

    assign port1ModemCtrlReg        = mcr1_r;
    assign port2ModemCtrlReg        = mcr2_r;
    assign port1ModemStatusReg      = status1;
    assign port2ModemStatusReg      = status2;
    assign port1SendRequestN        = rts1N_r;
    assign port1TerminalReadyN      = dtr1N_r;
    assign port2SendRequestN        = rts2N_r;
    assign port2SendRequestOe       = strapDone_r;
    assign port2TerminalReadyN      = dtr2N_r;
    assign port1RxData              = rx1_r;
    assign port1SerialOut           = tx1_r;
    assign port2RxData              = rx2_r;
    assign port2IrRxData            = irRx2_r;
    assign port2SerialOrInfraredOut = out2_r;
    assign configBaseStrap          = strap_r;
    assign configIndexBase          = cfgBase_r;

    // Checks; edges are only claimed once input history exists
    logic [1:0] settle_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            settle_r <= 2'b00;
        end else begin
            settle_r <= {settle_r[0], 1'b1};
        end
    end

    wire logic settled = settle_r[1];

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (sys_rst);

    property p_rts_write;
        port1ModemCtrlWe && port1ModemCtrlWdata[MCR_RTS_BIT]
            && !port1ModemCtrlWdata[MCR_LOOP_BIT]
            |=> ##1 !port1SendRequestN;
    endproperty
    a_rts_write: assert property (p_rts_write)
        else $error("send-request did not follow control bit");

    property p_reset_inactive;
        @(posedge clk) disable iff (1'b0)
        sys_rst |-> port1SendRequestN && port2SendRequestN;
    endproperty
    a_reset_inactive: assert property (p_reset_inactive)
        else $error("send-request active during reset");

    property p_rts_loop;
        mcr2_r[MCR_LOOP_BIT] && !port2ModemCtrlWe
            |=> port2SendRequestN [*2];
    endproperty
    a_rts_loop: assert property (p_rts_loop)
        else $error("send-request active in loop mode");

    property p_dtr_write;
        port2ModemCtrlWe && port2ModemCtrlWdata[MCR_DTR_BIT]
            && !port2ModemCtrlWdata[MCR_LOOP_BIT]
            |=> ##1 !port2TerminalReadyN;
    endproperty
    a_dtr_write: assert property (p_dtr_write)
        else $error("terminal-ready did not follow control bit");

    property p_dtr_reset;
        @(posedge clk) disable iff (1'b0)
        sys_rst |-> port1TerminalReadyN && port2TerminalReadyN;
    endproperty
    a_dtr_reset: assert property (p_dtr_reset)
        else $error("terminal-ready active during reset");

    property p_dtr_loop;
        mcr1_r[MCR_LOOP_BIT] |=> port1TerminalReadyN;
    endproperty
    a_dtr_loop: assert property (p_dtr_loop)
        else $error("terminal-ready active in loop mode");

    property p_cts_level;
        settled |-> port1ModemStatusReg[MSR_CTS_BIT]
            == !$past(port1ClearToSendN);
    endproperty
    a_cts_level: assert property (p_cts_level)
        else $error("status bit 4 not inverse of clear-to-send");

    property p_cts_delta;
        settled && $rose(port1ClearToSendN)
            |=> port1ModemStatusReg[MSR_DCTS_BIT];
    endproperty
    a_cts_delta: assert property (p_cts_delta)
        else $error("clear-to-send rise not flagged");

    property p_tx_free;
        settled |-> port1SerialOut == $past(port1TxData);
    endproperty
    a_tx_free: assert property (p_tx_free)
        else $error("transmit path disturbed");

    property p_dsr_level;
        settled |-> port2ModemStatusReg[MSR_DSR_BIT]
            == !$past(port2SetReadyN);
    endproperty
    a_dsr_level: assert property (p_dsr_level)
        else $error("status bit 5 not inverse of set-ready");

    property p_dsr_delta;
        settled && $rose(port2SetReadyN)
            |=> port2ModemStatusReg[MSR_DDSR_BIT];
    endproperty
    a_dsr_delta: assert property (p_dsr_delta)
        else $error("set-ready rise not flagged");

    property p_dcd_level;
        settled |-> port1ModemStatusReg[MSR_DCD_BIT]
            == !$past(port1CarrierDetectN);
    endproperty
    a_dcd_level: assert property (p_dcd_level)
        else $error("status bit 7 not inverse of carrier-detect");

    property p_dcd_delta;
        settled && $rose(port1CarrierDetectN)
            |=> port1ModemStatusReg[MSR_DDCD_BIT];
    endproperty
    a_dcd_delta: assert property (p_dcd_delta)
        else $error("carrier-detect rise not flagged");

    property p_ri_level;
        settled |-> port2ModemStatusReg[MSR_RI_BIT]
            == !$past(port2RingIndicateN);
    endproperty
    a_ri_level: assert property (p_ri_level)
        else $error("status bit 6 not inverse of ring-indicate");

    property p_ri_delta;
        settled && $rose(port1RingIndicateN)
            |=> port1ModemStatusReg[MSR_TERI_BIT];
    endproperty
    a_ri_delta: assert property (p_ri_delta)
        else $error("ring-indicate rise not flagged");

    property p_irq_change;
        settled && port1ModemIntEnable
            && $changed(port1RingIndicateN) |=> port1ModemIrq;
    endproperty
    a_irq_change: assert property (p_irq_change)
        else $error("modem change did not raise interrupt");

    property p_irq_off;
        !port2ModemIntEnable |=> !port2ModemIrq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt raised while disabled");

    property p_strap;
        $rose(strapDone_r) |-> configBaseStrap == $past(port2SendRequestIn)
            && configIndexBase == (configBaseStrap ? CFG_BASE_HIGH
                                                   : CFG_BASE_LOW);
    endproperty
    a_strap: assert property (p_strap)
        else $error("strap not latched at reset release");

    property p_ir_out;
        settled |-> port2SerialOrInfraredOut
            == ($past(port2IrMode) ? $past(port2IrTxData)
                                   : $past(port2TxData));
    endproperty
    a_ir_out: assert property (p_ir_out)
        else $error("port 2 transmit pin source wrong");

    property p_read_clear;
        settled && port1StatusRead && !$rose(port1ClearToSendN)
            |=> !port1ModemStatusReg[MSR_DCTS_BIT];
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status read did not clear change bit");

    c_loop: cover property (mcr1_r[MCR_LOOP_BIT] && mcr1_r[MCR_RTS_BIT]);
    c_irq: cover property (port1ModemIrq ##1 port1StatusRead);
    c_strap_high: cover property ($rose(strapDone_r) && configBaseStrap);
    c_set_wins: cover property (port2StatusRead && $rose(port2SetReadyN));

endmodule

`default_nettype wire

// file: bench/umhp_modem_model.sv
// Modem-side partner: handshake drivers and the strap resistor
`timescale 1ns/10ps
`default_nettype none

module umhp_modem_model
    import umhp_pkg::*;
(
    input  wire logic           clk,
    input  wire logic [3:0]     assert1,
    input  wire logic [3:0]     assert2,
    input  wire logic           strapHigh,
    input  wire logic           sendReq2N,
    input  wire logic           sendReq2Oe,
    output var  umhp_modem_in_t pins1N,
    output var  umhp_modem_in_t pins2N,
    output wire logic           sendReq2Wire
);
    // Resistor wins only while the device driver is off
    assign sendReq2Wire = sendReq2Oe ? sendReq2N : strapHigh;
    // Idle modem holds every handshake line deasserted
    initial begin
        pins1N = umhp_modem_in_t'(4'hf);
        pins2N = umhp_modem_in_t'(4'hf);
    end
    always @(posedge clk) begin
        pins1N <= umhp_modem_in_t'(~assert1);
        pins2N <= umhp_modem_in_t'(~assert2);
    end
endmodule
`default_nettype wire

// file: bench/test_uart_modem_handshake_pins.sv
// Self-checking bench for the modem handshake pin block
`timescale 1ns/10ps
`default_nettype none

module test_uart_modem_handshake_pins;
    import umhp_pkg::*;
    logic           clk, sys_rst, strapHigh, irMode, irTx;
    logic [1:0]     we, rd, ien, irq, rtsN, dtrN, txIn, serIn;
    logic [7:0]     wd [2];
    logic [7:0]     ctl [2];
    logic [7:0]     modem_status_reg [2];
    logic [3:0]     asrt [2];
    umhp_modem_in_t p1N, p2N;
    logic           s2Wire, s2Oe, rx1, so1, rx2, irRx2, so2, strap;
    logic [15:0]    base;
    int             n_mismatch, checks_done;

    always #2.5 clk = ~clk;

    umhp_top DUT (
        .clk(clk), .sys_rst(sys_rst),
        .port1ModemCtrlWe(we[0]), .port1ModemCtrlWdata(wd[0]),
        .port1ModemCtrlReg(ctl[0]), .port1StatusRead(rd[0]),
        .port1ModemStatusReg(modem_status_reg[0]), .port1ModemIntEnable(ien[0]),
        .port1ModemIrq(irq[0]), .port1SendRequestN(rtsN[0]),
        .port1TerminalReadyN(dtrN[0]),
        .port1ClearToSendN(p1N.clearToSendN), .port1SetReadyN(p1N.setReadyN),
        .port1CarrierDetectN(p1N.carrierDetectN),
        .port1RingIndicateN(p1N.ringIndicateN),
        .port1SerialIn(serIn[0]), .port1RxData(rx1),
        .port1TxData(txIn[0]), .port1SerialOut(so1),
        .port2ModemCtrlWe(we[1]), .port2ModemCtrlWdata(wd[1]),
        .port2ModemCtrlReg(ctl[1]), .port2StatusRead(rd[1]),
        .port2ModemStatusReg(modem_status_reg[1]), .port2ModemIntEnable(ien[1]),
        .port2ModemIrq(irq[1]), .port2SendRequestN(rtsN[1]),
        .port2SendRequestOe(s2Oe), .port2SendRequestIn(s2Wire),
        .port2TerminalReadyN(dtrN[1]),
        .port2ClearToSendN(p2N.clearToSendN), .port2SetReadyN(p2N.setReadyN),
        .port2CarrierDetectN(p2N.carrierDetectN),
        .port2RingIndicateN(p2N.ringIndicateN),
        .port2SerialOrInfraredIn(serIn[1]), .port2RxData(rx2),
        .port2IrRxData(irRx2), .port2IrMode(irMode),
        .port2TxData(txIn[1]), .port2IrTxData(irTx),
        .port2SerialOrInfraredOut(so2), .configBaseStrap(strap),
        .configIndexBase(base)
    );

    umhp_modem_model modem (
        .clk(clk), .assert1(asrt[0]), .assert2(asrt[1]),
        .strapHigh(strapHigh), .sendReq2N(rtsN[1]), .sendReq2Oe(s2Oe),
        .pins1N(p1N), .pins2N(p2N), .sendReq2Wire(s2Wire)
    );

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk1(string nm, logic e, logic g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Pins follow one cycle after the taking edge
    task automatic wr(int p, logic [7:0] d);
        @(posedge clk);
        we[p] <= 1'b1;
        wd[p] <= d;
        @(posedge clk);
        we[p] <= 1'b0;
        tick(2);
    endtask

    task automatic rdMsr(int p);
        @(posedge clk);
        rd[p] <= 1'b1;
        @(posedge clk);
        rd[p] <= 1'b0;
        tick(1);
    endtask

    // Model adds one register stage before the pins move
    task automatic drive(int p, logic [3:0] v);
        @(posedge clk);
        asrt[p] <= v;
        tick(4);
    endtask

    task automatic check_reset();
        chk16("sendReqN", 16'h0003, {14'h0, rtsN});
        chk16("termReadyN", 16'h0003, {14'h0, dtrN});
        chk16("ctrlRegs", 16'h0000, {ctl[1], ctl[0]});
        chk16("statusRegs", 16'h0000, {modem_status_reg[1], modem_status_reg[0]});
        chk16("cfgBase", CFG_BASE_LOW, base);
        chk1("strap", 1'b0, strap);
        chk1("strapOe", 1'b1, s2Oe);
    endtask

    task automatic ctrl_pins(int p);
        logic [7:0] tbl [6];
        tbl = '{8'h01, 8'h02, 8'h03, 8'h13, 8'h10, 8'h00};
        for (int i = 0; i < 6; i++) begin
            wr(p, tbl[i]);
            chk16("ctrlReg", {8'h00, tbl[i]}, {8'h00, ctl[p]});
            chk1("sendReqN", ~(tbl[i][1] & ~tbl[i][4]), rtsN[p]);
            chk1("termReadyN", ~(tbl[i][0] & ~tbl[i][4]), dtrN[p]);
        end
        // Back-to-back writes: only the last one may stick
        @(posedge clk);
        we[p] <= 1'b1;
        wd[p] <= 8'h02;
        @(posedge clk);
        wd[p] <= 8'h01;
        @(posedge clk);
        we[p] <= 1'b0;
        tick(2);
        chk16("sendTermN", 16'h0002, {14'h0, rtsN[p], dtrN[p]});
        wr(p, 8'h00);
    endtask

    task automatic status_flags(int p);
        @(posedge clk);
        ien[p] <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            drive(p, 4'h1 << k);
            chk16("level", 16'h0010 << k, {8'h00, modem_status_reg[p]});
            chk1("irq", 1'b1, irq[p]);
            rdMsr(p);
            chk1("irqAfterRead", 1'b0, irq[p]);
            drive(p, 4'h0);
            chk16("delta", 16'h0001 << k, {8'h00, modem_status_reg[p]});
            rdMsr(p);
            chk16("msrCleared", 16'h0000, {8'h00, modem_status_reg[p]});
        end
    endtask

    task automatic irq_mask(int p);
        @(posedge clk);
        ien[p] <= 1'b0;
        drive(p, 4'h8);
        chk1("irqMasked", 1'b0, irq[p]);
        @(posedge clk);
        ien[p] <= 1'b1;
        tick(2);
        chk1("irqUnmasked", 1'b1, irq[p]);
        rdMsr(p);
        drive(p, 4'h0);
        rdMsr(p);
        chk1("irqIdle", 1'b0, irq[p]);
    endtask

    task automatic serial_paths();
        @(posedge clk);
        serIn <= 2'b00;
        txIn <= 2'b10;
        irTx <= 1'b0;
        tick(2);
        chk16("rxPaths", 16'h0000, {13'h0, rx1, rx2, irRx2});
        chk16("txPaths", 16'h0001, {14'h0, so1, so2});
        @(posedge clk);
        irMode <= 1'b1;
        asrt[0] <= 4'h1;
        asrt[1] <= 4'h1;
        tick(4);
        // Clear-to-send toggled mid-stream must not touch the transmitters
        chk16("txIrMode", 16'h0000, {14'h0, so1, so2});
        drive(0, 4'h0);
        drive(1, 4'h0);
        chk16("txAfterCts", 16'h0000, {14'h0, so1, so2});
    endtask

    task automatic strap_reset();
        wr(0, 8'h03);
        wr(1, 8'h03);
        @(posedge clk);
        strapHigh <= 1'b1;
        sys_rst <= 1'b1;
        tick(2);
        chk16("sendReqN", 16'h0003, {14'h0, rtsN});
        chk16("termReadyN", 16'h0003, {14'h0, dtrN});
        chk1("strapOe", 1'b0, s2Oe);
        tick(4);
        @(posedge clk);
        sys_rst <= 1'b0;
        tick(2);
        chk1("strap", 1'b1, strap);
        chk16("cfgBase", CFG_BASE_HIGH, base);
        chk16("ctrlRegs", 16'h0000, {ctl[1], ctl[0]});
    endtask

    initial begin
        clk = 1'b0;
        // Scheduled late so every reset process sees the rising edge
        sys_rst <= 1'b1;
        {we, rd, ien, irMode, irTx, strapHigh} = '0;
        txIn = 2'b11;
        serIn = 2'b11;
        wd = '{8'h00, 8'h00};
        asrt = '{4'h0, 4'h0};
        n_mismatch = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        tick(2);
        check_reset();
        for (int p = 0; p < 2; p++) begin
            ctrl_pins(p);
            status_flags(p);
            irq_mask(p);
        end
        serial_paths();
        strap_reset();
        report_and_stop();
    end

    // A hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
